// ### src/adsq_pkg.sv
// Package for the converter sequencer: register map, field positions,
// state codes and the structs that carry core traffic.
// Assumes a 40 MHz peripheral clock and a byte-addressed word port.
package adsq_pkg;

   // Register byte addresses, one aligned word each
   localparam logic [7:0] OFF_MODE_A = 8'h00;  // Normal conversion control
   localparam logic [7:0] OFF_MODE_B = 8'h04;  // Reference and channel select
   localparam logic [7:0] OFF_PRIO   = 8'h08;  // Top-priority control
   localparam logic [7:0] OFF_MON0   = 8'h0c;  // Monitor channel 0 control
   localparam logic [7:0] OFF_MON1   = 8'h10;  // Monitor channel 1 control
   localparam logic [7:0] OFF_THR0   = 8'h14;  // Monitor 0 threshold
   localparam logic [7:0] OFF_THR1   = 8'h18;  // Monitor 1 threshold
   localparam logic [7:0] OFF_RES0   = 8'h20;  // First result, then +4 each
   localparam logic [7:0] OFF_RESP   = 8'h40;  // Top-priority result

   // Sizes
   localparam int NRES  = 8;   // Normal result registers
   localparam int CH_W  = 3;   // Channel number width
   localparam int IDX_W = 4;   // Result index width, NRES is priority slot
   localparam int RES_W = 10;  // Conversion result width

   // Field positions
   localparam int MA_GO = 0;   // Normal start, write-only
   localparam int MA_SC = 1;   // Scan bit of repeat/scan
   localparam int MA_RP = 2;   // Repeat bit of repeat/scan
   localparam int MA_IT = 4;   // Interrupt timing, two bits
   localparam int MA_BZ = 6;   // Normal busy, read-only
   localparam int MA_DN = 7;   // Normal done, clear on read
   localparam int MB_RF = 0;   // Reference power on
   localparam int MB_FC = 1;   // Fixed channel, three bits
   localparam int MB_SL = 4;   // Last scan channel, three bits
   localparam int PR_CH = 0;   // Priority channel, three bits
   localparam int PR_GO = 3;   // Priority start, write-only
   localparam int PR_BZ = 4;   // Priority busy
   localparam int PR_DN = 5;   // Priority done, clear on read
   localparam int MN_EN = 0;   // Monitor enable
   localparam int MN_DR = 1;   // Direction: 1 larger, 0 smaller
   localparam int MN_SL = 2;   // Watched result, three bits
   localparam int VAL_LO = 6;  // Result and threshold low bit
   localparam int VAL_HI = 15; // Result and threshold high bit
   localparam int RS_OV = 1;   // Overrun flag
   localparam int RS_ST = 0;   // Stored flag

   // Repeat/scan modes and interrupt timing codes
   localparam logic [1:0] MODE_FIX_SINGLE  = 2'h0;
   localparam logic [1:0] MODE_SCAN_SINGLE = 2'h1;
   localparam logic [1:0] MODE_FIX_REPEAT  = 2'h2;
   localparam logic [1:0] MODE_SCAN_REPEAT = 2'h3;
   localparam logic [1:0] ITM_EACH  = 2'h0;   // Interrupt every conversion
   localparam logic [1:0] ITM_FOUR  = 2'h1;   // Interrupt every fourth
   localparam logic [1:0] FOUR_LAST = 2'h3;   // Slot of the fourth result

   // Reference settle time software must wait
   localparam int REF_SETTLE_NS = 3000;
   localparam int CLK_NS        = 25;
   localparam int REF_SETTLE_CY = (REF_SETTLE_NS + CLK_NS - 1) / CLK_NS;

   // Sequencer states, one-hot
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_NORM = 3'b010,
      ST_PRIO = 3'b100
   } adsq_st_t;

   // Request to the conversion core
   typedef struct packed {
      logic            start;    // One-cycle start, restarts a running one
      logic [CH_W-1:0] channel;  // Input to convert
   } adsq_conv_req_t;

   // Answer from the conversion core
   typedef struct packed {
      logic             done;    // One-cycle completion
      logic [RES_W-1:0] data;    // Result, valid with done
   } adsq_conv_rsp_t;

   // Whole sequencer state
   typedef struct packed {
      adsq_st_t                    st;
      logic [1:0]                  modeRs;
      logic [1:0]                  irq_timing_select;
      logic                        normBusy;
      logic                        normDone;
      logic                        refOn;
      logic [CH_W-1:0]             fixCh;
      logic [CH_W-1:0]             scanLast;
      logic [CH_W-1:0]             prioCh;
      logic                        prioBusy;
      logic                        prioDone;
      logic [1:0]                  monEn;
      logic [1:0]                  monDir;
      logic [1:0][CH_W-1:0]        monSel;
      logic [1:0][RES_W-1:0]       thr;
      logic [NRES:0][RES_W-1:0]    resVal;
      logic [NRES:0]               resSt;
      logic [NRES:0]               resOv;
      logic [CH_W-1:0]             curCh;
      logic [1:0]                  slot;
      logic [31:0]                 rdData;
      adsq_conv_req_t              req;
      logic                        irqNorm;
      logic                        irqPrio;
      logic [1:0]                  irqMon;
   } adsq_state_t;

endpackage

// ### src/adsq_seq.sv
// Converter sequencer: normal and top-priority conversion control,
// result registers with stored/overrun flags and two threshold monitors.
// Assumes the conversion core shares clk and answers each start with one
// done pulse; a new start aborts and replaces a running conversion.
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps

// Function
// (R01) Monitor 0 threshold in bits 15:6, rest zero
// (R02) Monitor 1 threshold in bits 15:6, rest zero
// (R03) Software writes threshold 0 only when disabled
// (R04) Software writes threshold 1 only when disabled
// (R05) Software enables reference, waits 3 us, starts
// (R06) Reference enable cleared switches reference off
// (R07) Repeat/scan bits pick one of four modes
// (R08) Fixed single: once, done, idle, interrupt
// (R09) Scan single: whole scan, done, idle, interrupt
// (R10) Fixed repeat: busy stays, interrupt per timing
// (R11) Scan repeat: busy stays, done each scan
// (R12) Reading normal done flag clears it
// (R13) Priority request pre-empts running normal conversion
// (R14) Priority always converts its channel once
// (R15) Priority completion: interrupt, done, busy clear
// (R16) Reading priority done flag clears it
// (R17) Priority request ignored while priority busy
// (R18) Two monitors, each with own enable
// (R19) Monitor compares result, direction picks larger/smaller
// (R20) Compare only when watched result is written
// (R21) Unread result overwritten, flags stay set
// (R22) Result word: value, overrun, stored flags
// (R23) Priority start keeps normal busy and done
// (R24) Normal resumes from the interrupted channel
// (R25) Each interrupt is a one-cycle pulse
module adsq_seq
   import adsq_pkg::*;
(
   input  wire logic           clk,
   input  wire logic           resetn,
   input  wire logic [7:0]     addr,
   input  wire logic [31:0]    wrData,
   input  wire logic           wrEn,
   input  wire logic           rdEn,
   output logic [31:0]         rdData,
   output adsq_conv_req_t      convReq,
   input  wire adsq_conv_rsp_t convRsp,
   output logic                referencePowerOn,
   output logic                normalDoneIrq,
   output logic                priorityDoneIrq,
   output logic [1:0]          thresholdIrq
);

   ////////////////////////////////////////////////////////////////////////
   // Decode

   adsq_state_t s_r;     // Registered state
   adsq_state_t s_nxt;   // Next state

   logic wrModeA;        // Write to normal control
   logic wrPrio;         // Write to priority control
   logic rdModeA;        // Read of normal control
   logic rdPrio;         // Read of priority control
   logic prioGo;         // Accepted priority start
   logic normGo;         // Accepted normal start
   logic convEnd;        // Core finished a conversion

   assign wrModeA = wrEn && (addr == OFF_MODE_A);
   assign wrPrio  = wrEn && (addr == OFF_PRIO);
   assign rdModeA = rdEn && (addr == OFF_MODE_A);
   assign rdPrio  = rdEn && (addr == OFF_PRIO);
   // Second priority start while one runs is dropped
   assign prioGo  = wrPrio && wrData[PR_GO] && !s_r.prioBusy;        // [R17]
   // Normal start only from rest; a priority start wins the same cycle
   assign normGo  = wrModeA && wrData[MA_GO] && !s_r.normBusy && !s_r.prioBusy && !prioGo;
   assign convEnd = convRsp.done && (s_r.st != ST_IDLE);

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      logic             store;     // A result is written this cycle
      logic [IDX_W-1:0] idx;       // Which result register
      logic             lastScan;  // Scan reached its last channel
      logic             repMode;   // Repeat bit, sampled live
      store    = 1'b0;
      idx      = '0;
      lastScan = 1'b0;
      repMode  = s_r.modeRs[1];
      s_nxt    = s_r;

      // Pulses last one cycle only
      s_nxt.req.start = 1'b0;                                          // [R25]
      s_nxt.irqNorm   = 1'b0;
      s_nxt.irqPrio   = 1'b0;
      s_nxt.irqMon    = 2'b00;
      s_nxt.rdData    = '0;

      // Read path, taken from the pre-clear values
      if (rdEn) begin
         unique case (addr)
            OFF_MODE_A: s_nxt.rdData = {24'h0, s_r.normDone, s_r.normBusy,
                                        s_r.irq_timing_select, 1'b0, s_r.modeRs, 1'b0};
            OFF_MODE_B: s_nxt.rdData = {25'h0, s_r.scanLast, s_r.fixCh, s_r.refOn};
            OFF_PRIO:   s_nxt.rdData = {26'h0, s_r.prioDone, s_r.prioBusy,
                                        1'b0, s_r.prioCh};
            OFF_MON0:   s_nxt.rdData = {27'h0, s_r.monSel[0], s_r.monDir[0],
                                        s_r.monEn[0]};
            OFF_MON1:   s_nxt.rdData = {27'h0, s_r.monSel[1], s_r.monDir[1],
                                        s_r.monEn[1]};
            OFF_THR0:   s_nxt.rdData = {16'h0, s_r.thr[0], 6'h00};     // [R01]
            OFF_THR1:   s_nxt.rdData = {16'h0, s_r.thr[1], 6'h00};     // [R02]
            default: begin
               s_nxt.rdData = '0;
            end
         endcase
         // Result words, normal ones and the priority one
         for (int i = 0; i <= NRES; i++) begin
            if (addr == OFF_RES0 + 8'(4 * i)) begin
               s_nxt.rdData = {16'h0, s_r.resVal[i], 4'h0,
                               s_r.resOv[i], s_r.resSt[i]};            // [R22]
               s_nxt.resSt[i] = 1'b0;
               s_nxt.resOv[i] = 1'b0;
            end
         end
      end

      // Read-clear of done flags, before any set below
      if (rdModeA) begin
         s_nxt.normDone = 1'b0;                                        // [R12]
      end
      if (rdPrio) begin
         s_nxt.prioDone = 1'b0;                                        // [R16]
      end

      // Register writes
      if (wrEn) begin
         unique case (addr)
            OFF_MODE_A: begin
               s_nxt.modeRs = {wrData[MA_RP], wrData[MA_SC]};          // [R07]
               s_nxt.irq_timing_select    = wrData[MA_IT +: 2];
            end
            OFF_MODE_B: begin
               s_nxt.refOn    = wrData[MB_RF];                         // [R06]
               s_nxt.fixCh    = wrData[MB_FC +: CH_W];
               s_nxt.scanLast = wrData[MB_SL +: CH_W];
            end
            OFF_PRIO: s_nxt.prioCh = wrData[PR_CH +: CH_W];
            OFF_MON0: begin
               s_nxt.monEn[0]  = wrData[MN_EN];                        // [R18]
               s_nxt.monDir[0] = wrData[MN_DR];
               s_nxt.monSel[0] = wrData[MN_SL +: CH_W];
            end
            OFF_MON1: begin
               s_nxt.monEn[1]  = wrData[MN_EN];                        // [R18]
               s_nxt.monDir[1] = wrData[MN_DR];
               s_nxt.monSel[1] = wrData[MN_SL +: CH_W];
            end
            // Taken even while enabled; software must not do that
            OFF_THR0: s_nxt.thr[0] = wrData[VAL_HI:VAL_LO];            // [R01] [R03]
            OFF_THR1: s_nxt.thr[1] = wrData[VAL_HI:VAL_LO];            // [R02] [R04]
            default: begin
               s_nxt.rdData = s_nxt.rdData;
            end
         endcase
      end

      // Sequencer
      unique case (s_r.st)
         ST_IDLE: begin
            if (normGo) begin
               s_nxt.st       = ST_NORM;
               s_nxt.normBusy = 1'b1;
               s_nxt.slot     = 2'h0;
               s_nxt.curCh    = wrData[MA_SC] ? CH_W'(0) : s_r.fixCh;
               s_nxt.req      = '{start: 1'b1,
                                  channel: wrData[MA_SC] ? CH_W'(0) : s_r.fixCh};
            end
         end
         ST_NORM: begin
            if (convEnd) begin
               store    = 1'b1;
               lastScan = !s_r.modeRs[0] || (s_r.curCh == s_r.scanLast);
               // Result slot by mode
               if (s_r.modeRs == MODE_FIX_REPEAT) begin
                  idx = (s_r.irq_timing_select == ITM_FOUR) ? IDX_W'(s_r.slot) : '0;
               end else begin
                  idx = IDX_W'(s_r.curCh);
               end
               if (s_r.modeRs[0] && !lastScan) begin
                  // Next channel of the scan
                  s_nxt.curCh = s_r.curCh + CH_W'(1);                  // [R09] [R11]
                  s_nxt.req   = '{start: 1'b1, channel: s_r.curCh + CH_W'(1)};
               end else if (repMode) begin
                  // Keep going, busy stays up
                  s_nxt.curCh = s_r.modeRs[0] ? CH_W'(0) : s_r.curCh;  // [R10] [R11]
                  s_nxt.req   = '{start: 1'b1,
                                  channel: s_r.modeRs[0] ? CH_W'(0) : s_r.curCh};
                  if (s_r.modeRs[0]) begin
                     s_nxt.normDone = 1'b1;                            // [R11]
                     s_nxt.irqNorm  = 1'b1;
                  end else if (s_r.irq_timing_select == ITM_FOUR) begin
                     s_nxt.slot = s_r.slot + 2'h1;
                     if (s_r.slot == FOUR_LAST) begin
                        s_nxt.normDone = 1'b1;                         // [R10]
                        s_nxt.irqNorm  = 1'b1;
                     end
                  end else begin
                     s_nxt.normDone = 1'b1;                            // [R10]
                     s_nxt.irqNorm  = 1'b1;
                  end
               end else begin
                  // Single pass over, or repeat stopped by software
                  s_nxt.st       = ST_IDLE;
                  s_nxt.normBusy = 1'b0;                               // [R08] [R09]
                  s_nxt.normDone = 1'b1;
                  s_nxt.irqNorm  = 1'b1;
               end
            end
            // Pre-emption aborts the running conversion; curCh is kept
            if (prioGo) begin
               s_nxt.st       = ST_PRIO;                               // [R13]
               s_nxt.prioBusy = 1'b1;                                  // [R23]
               s_nxt.req      = '{start: 1'b1, channel: wrData[PR_CH +: CH_W]};
               store          = 1'b0;
               s_nxt.normDone = rdModeA ? 1'b0 : s_r.normDone;         // [R23]
               s_nxt.normBusy = s_r.normBusy;
               s_nxt.curCh    = s_r.curCh;
               s_nxt.slot     = s_r.slot;
               s_nxt.irqNorm  = 1'b0;
            end
         end
         ST_PRIO: begin
            if (convEnd) begin
               store          = 1'b1;
               idx            = IDX_W'(NRES);
               s_nxt.prioBusy = 1'b0;                                  // [R15]
               s_nxt.prioDone = 1'b1;
               s_nxt.irqPrio  = 1'b1;
               if (s_r.normBusy) begin
                  // Resume where the normal sequence was cut off
                  s_nxt.st  = ST_NORM;                                 // [R24]
                  s_nxt.req = '{start: 1'b1, channel: s_r.curCh};
               end else begin
                  s_nxt.st = ST_IDLE;
               end
            end
         end
      endcase

      // Priority start from rest, single fixed channel
      if (prioGo && s_r.st == ST_IDLE) begin
         s_nxt.st       = ST_PRIO;                                     // [R14]
         s_nxt.prioBusy = 1'b1;
         s_nxt.req      = '{start: 1'b1, channel: wrData[PR_CH +: CH_W]};
      end

      // Result store; overrun when the old one was never read
      if (store) begin
         s_nxt.resVal[idx] = convRsp.data;                             // [R21]
         s_nxt.resOv[idx]  = s_r.resSt[idx] | s_nxt.resOv[idx];
         s_nxt.resSt[idx]  = 1'b1;
         // Monitors look only at the freshly written register
         for (int k = 0; k < 2; k++) begin
            if (s_r.monEn[k] && (idx == IDX_W'(s_r.monSel[k]))) begin  // [R20]
               s_nxt.irqMon[k] = s_r.monDir[k] ? (convRsp.data > s_r.thr[k])
                                               : (convRsp.data < s_r.thr[k]); // [R19]
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_r    <= '0;
         s_r.st <= ST_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state flops
   assign rdData           = s_r.rdData;
   assign convReq          = s_r.req;
   assign referencePowerOn = s_r.refOn;                                // [R06]
   assign normalDoneIrq    = s_r.irqNorm;
   assign priorityDoneIrq  = s_r.irqPrio;
   assign thresholdIrq     = s_r.irqMon;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   a_thr_read_zero: assert property (                                  // [R01]
      rdEn && (addr == OFF_THR0) |=> (rdData[5:0] == 6'h00) && (rdData[31:16] == 16'h0)
   ) else $error("threshold 0 reserved bits not zero");

   // Write, one idle cycle, then read back: the spacing software really uses
   a_thr1_round: assert property (                                     // [R02]
      wrEn && (addr == OFF_THR1) ##1 !wrEn ##1 rdEn && (addr == OFF_THR1)
      |=> rdData[15:6] == $past(wrData[15:6], 3)
   ) else $error("threshold 1 did not hold written value");

   a_single_done: assert property (                                    // [R08]
      s_r.st == ST_NORM && convEnd && !prioGo && s_r.modeRs == MODE_FIX_SINGLE
      |=> s_r.normDone && !s_r.normBusy && normalDoneIrq && s_r.st == ST_IDLE
   ) else $error("fixed single completion wrong");

   a_repeat_busy: assert property (                                    // [R10]
      s_r.st == ST_NORM && convEnd && s_r.modeRs[1] && !prioGo
      |=> s_r.normBusy && convReq.start
   ) else $error("repeat mode dropped busy");

   a_done_rdclear: assert property (                                   // [R12]
      rdModeA && !(s_r.st == ST_NORM && convEnd)
      |=> !s_r.normDone
   ) else $error("normal done not cleared by read");

   a_preempt_keep: assert property (                                   // [R23]
      s_r.st == ST_NORM && prioGo && !rdModeA
      |=> s_r.prioBusy && s_r.normBusy && s_r.normDone == $past(s_r.normDone)
         && s_r.st == ST_PRIO
   ) else $error("pre-emption disturbed normal flags");

   a_prio_done: assert property (                                      // [R15]
      s_r.st == ST_PRIO && convEnd
      |=> priorityDoneIrq && s_r.prioDone && !s_r.prioBusy ##1 !priorityDoneIrq
   ) else $error("priority completion wrong");

   a_resume_chan: assert property (                                    // [R24]
      s_r.st == ST_PRIO && convEnd && s_r.normBusy
      |=> convReq.start && convReq.channel == $past(s_r.curCh) && s_r.st == ST_NORM
   ) else $error("normal did not resume at cut channel");

   a_prio_ignore: assert property (                                    // [R17]
      s_r.st == ST_PRIO && wrPrio && !convEnd |=> !convReq.start
   ) else $error("second priority start not ignored");

   a_prio_rdclear: assert property (                                   // [R16]
      rdPrio && !(s_r.st == ST_PRIO && convEnd) |=> !s_r.prioDone
   ) else $error("priority done not cleared by read");

   a_mon_only_store: assert property (                                 // [R20]
      !convEnd |=> thresholdIrq == 2'b00
   ) else $error("monitor fired without a store");

   // Fixed single keeps curCh after the store, so it names the slot hit
   a_overrun_set: assert property (                                    // [R21]
      s_r.st == ST_NORM && convEnd && !prioGo && s_r.modeRs == MODE_FIX_SINGLE
         && s_r.resSt[s_r.curCh]
      |=> s_r.resOv[s_r.curCh] && s_r.resSt[s_r.curCh]
   ) else $error("overrun not flagged on overwrite");

   a_scan_end: assert property (                                       // [R09]
      s_r.st == ST_NORM && convEnd && !prioGo && s_r.modeRs == MODE_SCAN_SINGLE
         && s_r.curCh == s_r.scanLast
      |=> s_r.normDone && !s_r.normBusy && normalDoneIrq && s_r.st == ST_IDLE
   ) else $error("scan single completion wrong");

   // Last channel of a repeating scan: flag, pulse, and restart at zero
   a_scan_wrap: assert property (                                      // [R11]
      s_r.st == ST_NORM && convEnd && !prioGo && s_r.modeRs == MODE_SCAN_REPEAT
         && s_r.curCh == s_r.scanLast
      |=> s_r.normDone && s_r.normBusy && normalDoneIrq && convReq.start
         && convReq.channel == '0
   ) else $error("scan repeat wrap wrong");

   a_prio_chan: assert property (                                      // [R14]
      prioGo
      |=> s_r.st == ST_PRIO && convReq.start
         && convReq.channel == $past(wrData[PR_CH +: CH_W])
   ) else $error("priority start on wrong channel");

   a_mon_larger: assert property (                                     // [R19]
      s_r.st == ST_NORM && convEnd && !prioGo && s_r.modeRs == MODE_FIX_SINGLE
         && s_r.monEn[0] && s_r.monDir[0] && s_r.curCh == s_r.monSel[0]
      |=> thresholdIrq[0] == ($past(convRsp.data) > $past(s_r.thr[0]))
   ) else $error("monitor 0 larger compare wrong");

endmodule // adsq_seq

// ### dv/adsq_core_model.sv
// Behavioural conversion core facing the sequencer.
// Assumes the shared clock; answers each start after LAT cycles.
`timescale 1ns/1ps
module adsq_core_model
   import adsq_pkg::*;
#(parameter int LAT = 4)
(
   input  wire logic           clk,
   input  wire logic           resetn,
   input  wire adsq_conv_req_t req,
   output adsq_conv_rsp_t      rsp
);
   logic [3:0]      cnt;  // Cycles left
   logic [CH_W-1:0] ch;   // Channel in work
   ////////////////////////////////////////////////////////////
   // New start aborts the old one; data churns outside done
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt <= 4'h0;
         ch  <= '0;
         rsp <= '0;
      end else begin
         rsp.done <= 1'b0;
         rsp.data <= ~rsp.data;  // No stale value to lean on
         if (req.start) begin
            cnt <= 4'(LAT);
            ch  <= req.channel;
         end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
            if (cnt == 4'h1) begin
               rsp.done <= 1'b1;
               rsp.data <= {ch, 7'h15};
            end
         end
      end
   end
endmodule // adsq_core_model

// ### dv/tb_adsq_seq.sv
// Bench for the converter sequencer: register tasks and sequences.
// Assumes the core model answers with value {channel, 7'h15}.
`timescale 1ns/1ps
module tb_adsq_seq;
   import adsq_pkg::*;
   logic           clk, resetn, wrEn, rdEn, refOn, irqN, irqP;
   logic [7:0]     addr;
   logic [31:0]    wrData, rdData, q;
   logic [1:0]     irqM;
   adsq_conv_req_t convReq;
   adsq_conv_rsp_t convRsp;
   int             badCount, nCompared;
   int             cnt [5];  // Pulses: norm, prio, mon0, mon1, start
   adsq_seq adsq_seq_i (.clk(clk), .resetn(resetn), .addr(addr), .wrData(wrData),
      .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .convReq(convReq), .convRsp(convRsp),
      .referencePowerOn(refOn), .normalDoneIrq(irqN), .priorityDoneIrq(irqP),
      .thresholdIrq(irqM));
   adsq_core_model adsq_core_model_i (.clk(clk), .resetn(resetn), .req(convReq),
      .rsp(convRsp));
   ////////////////////////////////////////////////////////////
   // Pulse counters; a stretched pulse shows as a wrong count
   always @(posedge clk) begin
      cnt[0] += int'(irqN === 1'b1);
      cnt[1] += int'(irqP === 1'b1);
      cnt[2] += int'(irqM[0] === 1'b1);
      cnt[3] += int'(irqM[1] === 1'b1);
      cnt[4] += int'(convReq.start === 1'b1);
   end
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   function automatic logic [31:0] rw(input logic [2:0] ch, input logic [1:0] f);
      return {16'h0, ch, 7'h15, 4'h0, f};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr   <= a;
      wrData <= d;
      wrEn   <= 1'b1;
      @(posedge clk);
      wrEn <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rdEn <= 1'b1;
      @(posedge clk);
      rdEn <= 1'b0;
      #1 v = rdData;  // Only cycle it is valid
   endtask
   task automatic chkw(input logic [31:0] got, input logic [31:0] exp);
      nCompared++;
      if (got !== exp) begin
         badCount++;
         $display("BAD %0t word %h want %h", $time, got, exp);
      end
   endtask
   task automatic chkn(input int got, input int exp);
      nCompared++;
      if (got != exp) begin
         badCount++;
         $display("BAD %0t count %0d want %0d", $time, got, exp);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      rd(a, v);
      chkw(v, exp);
   endtask
   // Bounded wait for a pulse counter
   task automatic waitc(input int k, input int tgt);
      for (int i = 0; i < 400 && cnt[k] < tgt; i++) @(posedge clk);
      #1;
   endtask
   task automatic close_out();
      $display("Compared %0d, bad %0d", nCompared, badCount);
      if (badCount == 0 && nCompared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #(25 * 20000);
      badCount++;
      close_out();
   end
   ////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {resetn, wrEn, rdEn, addr, wrData} = '0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      rc(OFF_THR0, 32'h0);
      wr(OFF_THR0, 32'hffffffff);
      rc(OFF_THR0, 32'h0000ffc0);
      wr(OFF_THR1, 32'hffffffff);
      rc(OFF_THR1, 32'h0000ffc0);
      rc(8'h1c, 32'h0);
      wr(OFF_THR0, 32'h00004000);
      wr(OFF_MODE_B, 32'h0000000b);
      chkw(32'(refOn), 32'h1);
      repeat (REF_SETTLE_CY) @(posedge clk);
      wr(OFF_MON0, 32'h00000017);
      wr(OFF_MON1, 32'h00000015);
      wr(OFF_MODE_A, 32'h00000001);
      waitc(0, 1);
      chkn(cnt[2] + cnt[3], 2);
      rc(OFF_MODE_A, 32'h00000080);
      rc(OFF_MODE_A, 32'h0);
      wr(OFF_MODE_A, 32'h00000001);
      waitc(0, 2);
      rc(8'h34, rw(3'h5, 2'h3));
      rc(8'h34, rw(3'h5, 2'h0));
      wr(OFF_MODE_B, 32'h0000002b);
      wr(OFF_MODE_A, 32'h00000003);
      waitc(0, 3);
      chkn(cnt[4], 5);
      rc(OFF_MODE_A, 32'h00000082);
      rc(8'h28, rw(3'h2, 2'h1));
      wr(OFF_MODE_A, 32'h00000007);
      repeat (6) @(posedge clk);
      wr(OFF_PRIO, 32'h0000000f);
      wr(OFF_PRIO, 32'h0000000f);
      waitc(1, 1);
      repeat (40) @(posedge clk);
      chkn(cnt[1], 1);
      rc(OFF_PRIO, 32'h00000027);
      rc(OFF_PRIO, 32'h00000007);
      rc(OFF_RESP, rw(3'h7, 2'h1));
      rd(OFF_MODE_A, q);
      chkw(q & 32'h40, 32'h40);
      chkn(int'(cnt[0] >= 5), 1);
      wr(OFF_MODE_A, 32'h00000002);
      repeat (40) @(posedge clk);
      rd(OFF_MODE_A, q);
      chkw(q & 32'h40, 32'h0);
      wr(OFF_MODE_B, 32'h0000000b);
      wr(OFF_MODE_A, 32'h00000005);
      repeat (40) @(posedge clk);
      rd(OFF_MODE_A, q);
      chkw(q & 32'hc0, 32'hc0);
      chkn(cnt[2] + cnt[3], 4);
      wr(OFF_MODE_A, 32'h00000000);
      repeat (10) @(posedge clk);
      wr(OFF_MODE_A, 32'h00000015);
      waitc(0, cnt[0] + 1);
      rc(8'h2c, rw(3'h5, 2'h1));
      wr(OFF_MODE_B, 32'h0);
      chkw(32'(refOn), 32'h0);
      close_out();
   end
endmodule // tb_adsq_seq
